// ---- hw/pcc_clock_reset_ctrl.sv ----
// Summary of operation
// - Restart bit self-clears, reads zero, zero ignored.
// - Restart clears core state, keeps registers.
// - Status bit seven reads synthesiser enabled.
// - Band field bits 3:1, default 101.
// - Bit zero picks reference or lane clock.
// - Lane clock divided by code plus one.
// - Reference multiplied by code plus one.
// - Enable bit runs synthesiser with settings.
// - Registers reached over two-wire port, auto-increment.
module pcc_clock_reset_ctrl #(
  parameter int LOCK_CYCLES = pcc_pkg::LOCK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic addr_strap,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic reference_input_clock_tick,
  input wire logic lane_clock_tick,
  output logic pix_clk_en,
  output logic pll_locked,
  output logic [2:0] lvds_band,
  output logic core_reset_pulse
);

  if (LOCK_CYCLES < 1 || LOCK_CYCLES > 24'hFFFFFF) begin : g_chk
    $error("LOCK_CYCLES out of range");
  end

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ACK_A = 9'h004,
    ST_SUB = 9'h008,
    ST_ACK_S = 9'h010,
    ST_WDATA = 9'h020,
    ST_ACK_W = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK = 9'h100
  } pcc_i2c_state_t;

  typedef struct packed {
    pcc_i2c_state_t state;
    logic scl_prev;
    logic sda_prev;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic done;
    logic rw;
    logic master_ack;
    logic drive_low;
    logic [7:0] sub;
    pcc_pkg::pcc_regs_t regs;
    logic restart;
    logic [23:0] lock_cnt;
    logic locked;
  } pcc_ctrl_state_t;

  pcc_ctrl_state_t st_reg;
  pcc_ctrl_state_t st_next;
  logic pix_tick;

  // Read view of the register map; unmapped and write-only addresses read zero.
  function automatic logic [7:0] read_reg(input logic [7:0] a, input pcc_pkg::pcc_regs_t r);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      pcc_pkg::ADDR_OUTCLK: begin
        d[pcc_pkg::STAT_BIT] = r.pll_en;
        d[pcc_pkg::BAND_LSB +: 3] = r.band;
        d[pcc_pkg::SRC_BIT] = r.src;
      end
      pcc_pkg::ADDR_RATIO: begin
        d[pcc_pkg::DIV_LSB +: 5] = r.div;
        d[pcc_pkg::MULT_LSB +: 2] = r.mult;
      end
      pcc_pkg::ADDR_SYNTH: d[pcc_pkg::EN_BIT] = r.pll_en;
      default: d = 8'h00;
    endcase
    return d;
  endfunction : read_reg

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise = scl_in && !st_reg.scl_prev;
  assign scl_fall = !scl_in && st_reg.scl_prev;
  assign start_cond = scl_in && st_reg.scl_prev && st_reg.sda_prev && !sda_in;
  assign stop_cond = scl_in && st_reg.scl_prev && !st_reg.sda_prev && sda_in;

  always_comb begin
    st_next = st_reg;
    st_next.scl_prev = scl_in;
    st_next.sda_prev = sda_in;
    st_next.restart = 1'b0;
    // Shift in on rising edges while the master sends.
    if (scl_rise && (st_reg.state == ST_ADDR || st_reg.state == ST_SUB || st_reg.state == ST_WDATA)) begin
      st_next.shreg = {st_reg.shreg[6:0], sda_in};
      st_next.bitcnt = st_reg.bitcnt + 3'h1;
      st_next.done = (st_reg.bitcnt == 3'h7);
    end
    case (st_reg.state)
      ST_IDLE: st_next.drive_low = 1'b0;
      ST_ADDR: begin
        if (scl_fall && st_reg.done) begin
          st_next.done = 1'b0;
          if (st_reg.shreg[7:1] == {pcc_pkg::TARGET_ADDR_HI, addr_strap}) begin
            st_next.rw = st_reg.shreg[0];
            st_next.drive_low = 1'b1;
            st_next.state = ST_ACK_A;
          end else begin
            st_next.state = ST_IDLE;
          end
        end
      end
      ST_ACK_A: begin
        if (scl_fall) begin
          st_next.bitcnt = 3'h0;
          if (st_reg.rw) begin
            st_next.shreg = read_reg(st_reg.sub, st_reg.regs);
            st_next.drive_low = !st_next.shreg[7];
            st_next.state = ST_RDATA;
          end else begin
            st_next.drive_low = 1'b0;
            st_next.state = ST_SUB;
          end
        end
      end
      ST_SUB: begin
        if (scl_fall && st_reg.done) begin
          st_next.done = 1'b0;
          st_next.sub = st_reg.shreg;
          st_next.drive_low = 1'b1;
          st_next.state = ST_ACK_S;
        end
      end
      ST_ACK_S, ST_ACK_W: begin
        if (scl_fall) begin
          st_next.drive_low = 1'b0;
          st_next.bitcnt = 3'h0;
          st_next.state = ST_WDATA;
        end
      end
      ST_WDATA: begin
        if (scl_fall && st_reg.done) begin
          st_next.done = 1'b0;
          case (st_reg.sub)
            pcc_pkg::ADDR_RESTART: st_next.restart = st_reg.shreg[pcc_pkg::RESTART_BIT];
            pcc_pkg::ADDR_OUTCLK: begin
              st_next.regs.band = st_reg.shreg[pcc_pkg::BAND_LSB +: 3];
              st_next.regs.src = st_reg.shreg[pcc_pkg::SRC_BIT];
            end
            pcc_pkg::ADDR_RATIO: begin
              st_next.regs.div = st_reg.shreg[pcc_pkg::DIV_LSB +: 5];
              st_next.regs.mult = st_reg.shreg[pcc_pkg::MULT_LSB +: 2];
            end
            pcc_pkg::ADDR_SYNTH: st_next.regs.pll_en = st_reg.shreg[pcc_pkg::EN_BIT];
            default: st_next.regs = st_reg.regs;
          endcase
          st_next.sub = st_reg.sub + 8'h01;
          st_next.drive_low = 1'b1;
          st_next.state = ST_ACK_W;
        end
      end
      ST_RDATA: begin
        if (scl_rise) begin
          st_next.bitcnt = st_reg.bitcnt + 3'h1;
          st_next.done = (st_reg.bitcnt == 3'h7);
        end
        if (scl_fall) begin
          if (st_reg.done) begin
            st_next.done = 1'b0;
            st_next.drive_low = 1'b0;
            st_next.sub = st_reg.sub + 8'h01;
            st_next.state = ST_RACK;
          end else begin
            st_next.shreg = {st_reg.shreg[6:0], 1'b0};
            st_next.drive_low = !st_reg.shreg[6];
          end
        end
      end
      ST_RACK: begin
        if (scl_rise) begin
          st_next.master_ack = !sda_in;
        end
        if (scl_fall) begin
          st_next.bitcnt = 3'h0;
          if (st_reg.master_ack) begin
            st_next.shreg = read_reg(st_reg.sub, st_reg.regs);
            st_next.drive_low = !st_next.shreg[7];
            st_next.state = ST_RDATA;
          end else begin
            st_next.state = ST_IDLE;
          end
        end
      end
      default: st_next.state = ST_IDLE;
    endcase
    // Bus conditions override everything else in the serial engine.
    if (start_cond) begin
      st_next.state = ST_ADDR;
      st_next.bitcnt = 3'h0;
      st_next.done = 1'b0;
      st_next.drive_low = 1'b0;
    end else if (stop_cond) begin
      st_next.state = ST_IDLE;
      st_next.drive_low = 1'b0;
    end
    // Lock timer restarts whenever the synthesiser is off or the core is restarted.
    if (!st_reg.regs.pll_en || st_reg.restart) begin
      st_next.lock_cnt = 24'h000000;
      st_next.locked = 1'b0;
    end else if (!st_reg.locked) begin
      if (st_reg.lock_cnt == 24'(LOCK_CYCLES - 1)) begin
        st_next.locked = 1'b1;
      end else begin
        st_next.lock_cnt = st_reg.lock_cnt + 24'h000001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.scl_prev <= 1'b1;
      st_reg.sda_prev <= 1'b1;
      st_reg.regs.band <= pcc_pkg::BAND_RESET;
      st_reg.regs.div <= pcc_pkg::DIV_RESET;
      st_reg.regs.mult <= pcc_pkg::MULT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  pcc_pkg::pcc_clk_cfg_t clk_cfg;
  assign clk_cfg = '{src: st_reg.regs.src, div: st_reg.regs.div, mult: st_reg.regs.mult};

  // The generator is held clear while disabled or restarted, so a setting written while disabled starts from a clean phase.
  pcc_pixel_clock_gen #(
    .PERIOD_W(pcc_pkg::PERIOD_W)
  ) u_gen (
    .clk(clk),
    .rst_b(rst_b),
    .clear(st_reg.restart || !st_reg.regs.pll_en),
    .cfg(clk_cfg),
    .reference_input_clock_tick(reference_input_clock_tick),
    .lane_clock_tick(lane_clock_tick),
    .pix_tick(pix_tick)
  );

  assign sda_out = 1'b0;
  assign sda_oe = st_reg.drive_low;
  assign pix_clk_en = pix_tick;
  assign pll_locked = st_reg.locked;
  assign lvds_band = st_reg.regs.band;
  assign core_reset_pulse = st_reg.restart;

endmodule : pcc_clock_reset_ctrl

// ---- hw/pcc_pkg.sv ----
package pcc_pkg;

  // Register sub-addresses on the serial register port.
  localparam logic [7:0] ADDR_RESTART = 8'h09;
  localparam logic [7:0] ADDR_OUTCLK = 8'h0A;
  localparam logic [7:0] ADDR_RATIO = 8'h0B;
  localparam logic [7:0] ADDR_SYNTH = 8'h0D;

  // Field positions.
  localparam int RESTART_BIT = 0;
  localparam int STAT_BIT = 7;
  localparam int BAND_LSB = 1;
  localparam int SRC_BIT = 0;
  localparam int DIV_LSB = 3;
  localparam int MULT_LSB = 0;
  localparam int EN_BIT = 0;

  // Reset values.
  localparam logic [2:0] BAND_RESET = 3'h5;
  localparam logic [4:0] DIV_RESET = 5'h00;
  localparam logic [1:0] MULT_RESET = 2'h0;
  localparam logic DIV_MAX = 1'b1;
  localparam logic [4:0] DIV_LAST_CODE = 5'h18;

  // Upper six bits of the serial target address; the low bit comes from a strap pin.
  localparam logic [5:0] TARGET_ADDR_HI = 6'h16;

  // Timing: lock wait after the synthesiser is enabled.
  localparam int CLK_MHZ = 125;
  localparam int LOCK_TIME_US = 3000;
  localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;

  // Width of the reference period measurement.
  localparam int PERIOD_W = 16;

  typedef struct packed {
    logic pll_en;
    logic [4:0] div;
    logic [1:0] mult;
    logic [2:0] band;
    logic src;
  } pcc_regs_t;

  typedef struct packed {
    logic src;
    logic [4:0] div;
    logic [1:0] mult;
  } pcc_clk_cfg_t;

endpackage : pcc_pkg

// ---- hw/pcc_pixel_clock_gen.sv ----
module pcc_pixel_clock_gen #(
  parameter int PERIOD_W = pcc_pkg::PERIOD_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire pcc_pkg::pcc_clk_cfg_t cfg,
  input wire logic reference_input_clock_tick,
  input wire logic lane_clock_tick,
  output logic pix_tick
);

  if (PERIOD_W < 4) begin : g_chk
    $error("PERIOD_W too small");
  end

  typedef struct packed {
    logic [4:0] lane_cnt;
    logic [PERIOD_W-1:0] ref_cnt;
    logic [PERIOD_W-1:0] period;
    logic [PERIOD_W+1:0] acc;
    logic [1:0] extra;
    logic tick;
  } pcc_gen_state_t;

  pcc_gen_state_t st_reg;
  pcc_gen_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (clear) begin
      st_next = '0;
    end else if (cfg.src) begin
      // Lane clock divided by code plus one.
      if (lane_clock_tick) begin
        if (st_reg.lane_cnt >= cfg.div) begin
          st_next.lane_cnt = 5'h00;
          st_next.tick = 1'b1;
        end else begin
          st_next.lane_cnt = st_reg.lane_cnt + 5'h01;
        end
      end
    end else begin
      // Reference multiplied by code plus one: extra ticks spread over the last measured period.
      if (reference_input_clock_tick) begin
        st_next.period = st_reg.ref_cnt + PERIOD_W'(1);
        st_next.ref_cnt = '0;
        st_next.acc = '0;
        st_next.extra = 2'h0;
        st_next.tick = 1'b1;
      end else begin
        if (st_reg.ref_cnt != '1) begin
          st_next.ref_cnt = st_reg.ref_cnt + PERIOD_W'(1);
        end
        st_next.acc = st_reg.acc + (PERIOD_W+2)'({1'b0, cfg.mult} + 3'h1);
        if (st_reg.period != '0 && st_next.acc >= (PERIOD_W+2)'(st_reg.period)) begin
          st_next.acc = st_next.acc - (PERIOD_W+2)'(st_reg.period);
          if (st_reg.extra < cfg.mult) begin
            st_next.extra = st_reg.extra + 2'h1;
            st_next.tick = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pix_tick = st_reg.tick;

endmodule : pcc_pixel_clock_gen

// ---- verification/pcc_clock_reset_ctrl_chk.sv ----
module pcc_clock_reset_ctrl_chk #(
  parameter int LOCK_CYCLES = pcc_pkg::LOCK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic addr_strap,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic reference_input_clock_tick,
  input wire logic lane_clock_tick,
  input wire logic pix_clk_en,
  input wire logic pll_locked,
  input wire logic [2:0] lvds_band,
  input wire logic core_reset_pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  chk_restart_one_cycle: assert property (core_reset_pulse |=> !core_reset_pulse)
    else $error("restart pulse wider than one cycle");
  chk_restart_scl_low: assert property (core_reset_pulse |-> !scl_in && !$past(scl_in))
    else $error("restart pulse outside the acknowledge slot");
  chk_restart_keeps_band: assert property (core_reset_pulse |=> $stable(lvds_band))
    else $error("restart changed the band field");
  chk_restart_drops_lock: assert property (core_reset_pulse |=> !pll_locked [*4])
    else $error("lock survived a restart");
  chk_reset_defaults: assert property ($past(!rst_b) |-> lvds_band == 3'h5 && !pll_locked && !sda_oe)
    else $error("wrong state after reset");
  chk_band_scl_low: assert property ($changed(lvds_band) |-> !scl_in)
    else $error("band changed while serial clock high");
  chk_sda_never_high: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  chk_oe_rise_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data line pulled while serial clock high");
  chk_oe_steady_scl_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data line moved while serial clock high");
  cov_restart: cover property (core_reset_pulse);
  cov_lock: cover property ($rose(pll_locked));
  cov_ack: cover property ($rose(sda_oe));
  cov_pix: cover property (pix_clk_en);
endmodule : pcc_clock_reset_ctrl_chk

bind pcc_clock_reset_ctrl pcc_clock_reset_ctrl_chk #(.LOCK_CYCLES(LOCK_CYCLES)) chk_i (
  .clk(clk), .rst_b(rst_b), .addr_strap(addr_strap), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .reference_input_clock_tick(reference_input_clock_tick),
  .lane_clock_tick(lane_clock_tick), .pix_clk_en(pix_clk_en), .pll_locked(pll_locked),
  .lvds_band(lvds_band), .core_reset_pulse(core_reset_pulse));

// ---- verification/pcc_clock_reset_ctrl_bench.sv ----
module pcc_clock_reset_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DEV_W = {pcc_pkg::TARGET_ADDR_HI, 2'h2};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic lane_tick = 1'b0;
  logic ref_tick = 1'b0;
  logic [7:0] cyc = 8'h00;
  int lane_cnt = 0;
  int ref_cnt = 0;
  int pix_cnt = 0;
  int rst_cnt = 0;
  int error_cnt = 0;
  int compares = 0;
  logic sda_out, sda_oe, pix_clk_en, pll_locked, core_reset_pulse;
  logic [2:0] lvds_band;
  // Open drain with pull-up: the wire is low if either side pulls.
  wire logic sda = sda_m & ~sda_oe;

  pcc_clock_reset_ctrl #(.LOCK_CYCLES(20)) uut (
    .clk(clk), .rst_b(rst_b), .addr_strap(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .reference_input_clock_tick(ref_tick), .lane_clock_tick(lane_tick),
    .pix_clk_en(pix_clk_en), .pll_locked(pll_locked), .lvds_band(lvds_band),
    .core_reset_pulse(core_reset_pulse));

  initial forever #4 clk = ~clk;

  always @(negedge clk) begin
    cyc <= cyc + 8'h01;
    lane_tick <= (cyc[1:0] == 2'h0);
    ref_tick <= (cyc[3:0] == 4'h0);
  end

  always @(posedge clk) begin
    lane_cnt <= lane_cnt + int'(lane_tick);
    ref_cnt <= ref_cnt + int'(ref_tick);
    pix_cnt <= pix_cnt + int'(pix_clk_en);
    rst_cnt <= rst_cnt + int'(core_reset_pulse);
  end

  task automatic wrap_up;
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic byte_x(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic a);
    logic [8:0] v;
    v = {d, mack};
    for (int i = 8; i >= 0; i--) begin
      scl = 1'b0;
      sda_m = v[i];
      tick(4);
      scl = 1'b1;
      tick(4);
      if (i > 0) q[i-1] = sda;
      else a = sda;
    end
  endtask : byte_x

  task automatic start_c;
    sda_m = 1'b0;
    tick(4);
  endtask : start_c

  task automatic stop_c;
    scl = 1'b0;
    sda_m = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b1;
    tick(4);
  endtask : stop_c

  task automatic wbyte(input logic [7:0] d, input logic nack);
    logic [7:0] q;
    logic a;
    byte_x(d, 1'b1, q, a);
    chk("ack", {7'h00, a}, {7'h00, nack});
  endtask : wbyte

  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    start_c;
    wbyte(DEV_W, 1'b0);
    wbyte(sub, 1'b0);
    wbyte(d, 1'b0);
    stop_c;
  endtask : wr

  // Bytes expected are packed first byte highest; the last byte is not acknowledged.
  task automatic rd(input logic [7:0] sub, input int n, input logic [31:0] exp);
    logic [7:0] q;
    logic a;
    start_c;
    wbyte(DEV_W, 1'b0);
    wbyte(sub, 1'b0);
    stop_c;
    start_c;
    wbyte(DEV_W | 8'h01, 1'b0);
    for (int i = 0; i < n; i++) begin
      byte_x(8'hFF, (i == n - 1), q, a);
      chk("read", q, exp[31-8*i -: 8]);
    end
    stop_c;
  endtask : rd

  task automatic t_defaults;
    chk("band", {5'h00, lvds_band}, 8'h05);
    rd(pcc_pkg::ADDR_RESTART, 4, 32'h000A0000);
    rd(pcc_pkg::ADDR_SYNTH, 1, 32'h00000000);
    start_c;
    wbyte({pcc_pkg::TARGET_ADDR_HI, 2'h0}, 1'b1);
    stop_c;
  endtask : t_defaults

  task automatic t_band;
    for (int b = 0; b < 8; b++) begin
      wr(pcc_pkg::ADDR_OUTCLK, {4'hF, 3'(b), 1'b0});
      rd(pcc_pkg::ADDR_OUTCLK, 1, {4'h0, 3'(b), 1'b0, 24'h0});
      chk("band", {5'h00, lvds_band}, 8'(b));
    end
  endtask : t_band

  // Counts generated pulses over a whole number of source ticks, so the phase does not matter.
  task automatic measure(input logic lane, input int n, input int exp);
    int l0;
    int p0;
    int k;
    l0 = lane ? lane_cnt : ref_cnt;
    for (k = 0; k < 40 && (lane ? lane_cnt : ref_cnt) == l0; k++) tick(1);
    if ((lane ? lane_cnt : ref_cnt) == l0) begin
      error_cnt++;
      wrap_up();
    end
    tick(2);
    p0 = pix_cnt;
    l0 = lane ? lane_cnt : ref_cnt;
    for (k = 0; k < 2000 && (lane ? lane_cnt : ref_cnt) != l0 + n; k++) tick(1);
    if ((lane ? lane_cnt : ref_cnt) != l0 + n) begin
      error_cnt++;
      wrap_up();
    end
    tick(2);
    chk("pixel pulses", 8'(pix_cnt - p0), 8'(exp));
  endtask : measure

  task automatic t_clock(input logic lane, input logic [4:0] d, input logic [1:0] m);
    int r0;
    wr(pcc_pkg::ADDR_SYNTH, 8'h00);
    wr(pcc_pkg::ADDR_RATIO, {d, 1'b0, m});
    wr(pcc_pkg::ADDR_OUTCLK, {7'h05, lane});
    // Status must have dropped with the enable bit while the band and source stay as written.
    rd(pcc_pkg::ADDR_OUTCLK, 1, {7'h05, lane, 24'h0});
    chk("lock", {7'h00, pll_locked}, 8'h00);
    wr(pcc_pkg::ADDR_SYNTH, 8'h01);
    rd(pcc_pkg::ADDR_OUTCLK, 1, {7'h45, lane, 24'h0});
    chk("lock", {7'h00, pll_locked}, 8'h01);
    r0 = rst_cnt;
    wr(pcc_pkg::ADDR_RESTART, 8'h00);
    chk("restarts", 8'(rst_cnt - r0), 8'h00);
    wr(pcc_pkg::ADDR_RESTART, 8'h01);
    chk("restarts", 8'(rst_cnt - r0), 8'h01);
    rd(pcc_pkg::ADDR_RATIO, 1, {d, 1'b0, m, 24'h0});
    // Four reference periods give the base pulse plus one extra per multiplier step each.
    measure(lane, lane ? 3 * (int'(d) + 1) : 4, lane ? 3 : 4 * (int'(m) + 1));
  endtask : t_clock

  initial begin
    tick(5);
    rst_b = 1'b1;
    t_defaults();
    t_band();
    t_clock(1'b1, 5'h00, 2'h0);
    t_clock(1'b1, 5'h02, 2'h0);
    t_clock(1'b1, 5'h18, 2'h0);
    t_clock(1'b0, 5'h00, 2'h0);
    t_clock(1'b0, 5'h00, 2'h3);
    wrap_up();
  end
endmodule : pcc_clock_reset_ctrl_bench
